// *** bench/mcsp_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcsp_osc_model #(
  parameter int FAST_DIV = 2,
  parameter int ULP_DIV  = 8,
  parameter int EXT_DIV  = 3,
  parameter int START    = 12
) (
  input  wire logic clk_sys,
  input  wire logic fast_run,
  input  wire logic ulp_run,
  output logic      fast_tick,
  output logic      ulp_tick,
  output logic      ext_tick,
  output logic      fast_ok,
  output logic      ulp_ok
);
  // Unpowered oscillators stand still and lose their start-up
  int fc = 0;
  int uc = 0;
  int ec = 0;
  int fs = 0;
  int us = 0;
  always @(posedge clk_sys) begin
    fc <= (fast_run === 1'h1) ? (fc + 1) % FAST_DIV : 0;
    uc <= (ulp_run === 1'h1) ? (uc + 1) % ULP_DIV : 0;
    ec <= (ec + 1) % EXT_DIV;
    fs <= (fast_run !== 1'h1) ? 0 : ((fs < START) ? fs + 1 : fs);
    us <= (ulp_run !== 1'h1) ? 0 : ((us < START) ? us + 1 : us);
  end
  assign fast_tick = (fast_run === 1'h1) && (fc == FAST_DIV - 1);
  assign ulp_tick  = (ulp_run === 1'h1) && (uc == ULP_DIV - 1);
  assign ext_tick  = (ec == EXT_DIV - 1);
  assign fast_ok   = (fs == START);
  assign ulp_ok    = (us == START);
endmodule
`default_nettype wire

// *** bench/tb_main_clock_select_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_main_clock_select_prescaler;
  typedef struct {
    logic [4:0] idx;
    logic [7:0] wd;
    logic [7:0] ex;
    int         dv;
  } mcsp_row_t;
  localparam logic [4:0] I_SRC = mcsp_pkg::IDX_SRC;
  localparam logic [4:0] I_PRE = mcsp_pkg::IDX_PRE;
  localparam logic [4:0] I_LCK = mcsp_pkg::IDX_LOCK;
  localparam logic [4:0] I_STA = mcsp_pkg::IDX_STAT;
  localparam logic [4:0] I_TRM = mcsp_pkg::IDX_FTRIM;
  localparam logic [4:0] I_TCO = mcsp_pkg::IDX_FTCO;
  localparam logic [4:0] I_UCT = mcsp_pkg::IDX_UCTL;
  logic        clk_sys = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        ccp_unlock = 1'h1;
  logic        fuse_calib_freeze = 1'h0;
  logic        fuse_freq_select = 1'h0;
  logic [5:0]  fuse_trim_16 = 6'h2A;
  logic [5:0]  fuse_trim_20 = 6'h11;
  logic [3:0]  fuse_tempco_16 = 4'h5;
  logic [3:0]  fuse_tempco_20 = 4'hA;
  logic        fast_osc_tick, ulp_osc_tick, ext_clk_tick;
  logic        fast_osc_analog_ok, ulp_osc_analog_ok;
  logic        periph_req_fast = 1'h0;
  logic        periph_req_ulp = 1'h0;
  logic        periph_req_ext = 1'h0;
  logic        sleep_active = 1'h0;
  logic        periph_uses_sysclk = 1'h0;
  logic        main_clk_en, per_clk_en, clk_out_pin;
  logic        fast_osc_run, ulp_osc_run;
  logic [5:0]  fast_osc_trim;
  logic [3:0]  fast_osc_tempco_trim;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  mcsp_row_t   rows [20] = '{
    '{I_PRE, 8'h01, 8'h01, 2},  '{I_PRE, 8'h03, 8'h03, 4},
    '{I_PRE, 8'h05, 8'h05, 8},  '{I_PRE, 8'h07, 8'h07, 16},
    '{I_PRE, 8'h09, 8'h09, 32}, '{I_PRE, 8'h0B, 8'h0B, 64},
    '{I_PRE, 8'h11, 8'h11, 6},  '{I_PRE, 8'h13, 8'h13, 10},
    '{I_PRE, 8'h15, 8'h15, 12}, '{I_PRE, 8'h17, 8'h17, 24},
    '{I_PRE, 8'h19, 8'h19, 48}, '{I_PRE, 8'h18, 8'h18, 1},
    '{I_PRE, 8'hE1, 8'h01, 2},  '{I_SRC, 8'h80, 8'h80, 0},
    '{I_SRC, 8'h82, 8'h80, 0},
    '{mcsp_pkg::IDX_FCTL, 8'hFF, 8'h02, 0}, '{I_UCT, 8'hFF, 8'h02, 0},
    '{I_TRM, 8'hFF, 8'h3F, 0},  '{I_TRM, 8'h15, 8'h15, 0},
    '{I_TCO, 8'hFF, 8'h0F, 0}};

  mcsp_clkctrl uut (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ccp_unlock, .fuse_calib_freeze, .fuse_freq_select,
    .fuse_trim_16, .fuse_trim_20, .fuse_tempco_16, .fuse_tempco_20,
    .fast_osc_tick, .ulp_osc_tick, .ext_clk_tick, .fast_osc_analog_ok,
    .ulp_osc_analog_ok, .periph_req_fast, .periph_req_ulp, .periph_req_ext,
    .sleep_active, .periph_uses_sysclk, .main_clk_en, .per_clk_en,
    .clk_out_pin, .fast_osc_run, .ulp_osc_run, .fast_osc_trim,
    .fast_osc_tempco_trim);

  mcsp_osc_model osc (
    .clk_sys(clk_sys), .fast_run(fast_osc_run), .ulp_run(ulp_osc_run),
    .fast_tick(fast_osc_tick), .ulp_tick(ulp_osc_tick),
    .ext_tick(ext_clk_tick), .fast_ok(fast_osc_analog_ok),
    .ulp_ok(ulp_osc_analog_ok));

  always #5 clk_sys = ~clk_sys;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [4:0] idx,
                     input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= {1'h0, idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, idx, d, r, e);
  endtask

  task automatic rd(input logic [4:0] idx, output logic [31:0] r);
    logic e;
    apb(1'h0, idx, 8'h00, r, e);
  endtask

  task automatic rdc(input string nm, input logic [4:0] idx,
                     input logic [7:0] x);
    logic [31:0] r;
    rd(idx, r);
    chk(nm, r, {24'h0, x});
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
  endtask

  // Main ticks between two prescaled ticks, wrapping tick included
  task automatic meas(output int n);
    int s;
    n = 0;
    s = 0;
    repeat (4000) if (s < 2) begin
      @(negedge clk_sys);
      if (s == 1 && main_clk_en === 1'h1) n++;
      if (per_clk_en === 1'h1) s++;
    end
  endtask

  task automatic cnt(input int c, output int m, output int o);
    m = 0;
    o = 0;
    // Let a changed sleep input reach the output flop first
    @(posedge clk_sys);
    repeat (c) begin
      @(negedge clk_sys);
      if (main_clk_en === 1'h1) m++;
      if (clk_out_pin === 1'h1) o++;
    end
  endtask

  task automatic wait_switch(output logic [31:0] v);
    int k;
    k = 0;
    do begin
      rd(I_STA, v);
      k++;
    end while (v[0] === 1'h1 && k < 100);
  endtask

  initial begin
    logic [31:0] v;
    logic        e;
    int          n, m, o;
    do_reset();
    rdc("src rst", I_SRC, 8'h00);
    rdc("pre rst", I_PRE, 8'h11);
    rdc("lock rst", I_LCK, 8'h00);
    rdc("trim rst", I_TRM, {2'h0, fuse_trim_16});
    rdc("tempco rst", I_TCO, {4'h0, fuse_tempco_16});
    chk("trim pin", fast_osc_trim, fuse_trim_16);
    chk("tempco pin", fast_osc_tempco_trim, fuse_tempco_16);
    chk("fast run", fast_osc_run, 1'h1);
    meas(n);
    chk("div rst", 32'(n), 32'h6);
    wr(I_STA, 8'hFF);
    rdc("status", I_STA, 8'h10);
    apb(1'h0, 5'h05, 8'h00, v, e);
    chk("unmapped data", v, 32'h0);
    chk("unmapped err", e, 1'h1);
    $display("reset test done");
    ccp_unlock <= 1'h1;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdc("reg rw", rows[i].idx, rows[i].ex);
      if (rows[i].dv != 0) begin
        meas(n);
        chk("divisor", 32'(n), 32'(rows[i].dv));
      end
    end
    $display("register table test done");
    cnt(100, m, o);
    chk("sys_clock_out_enable on", 32'(o), 32'(m));
    chk("main ticks", 32'(m != 0), 32'h1);
    @(posedge clk_sys);
    sleep_active <= 1'h1;
    cnt(100, m, o);
    chk("sys_clock_out_enable sleep", 32'(o), 32'h0);
    @(posedge clk_sys);
    periph_uses_sysclk <= 1'h1;
    cnt(100, m, o);
    chk("sys_clock_out_enable used", 32'(o), 32'(m));
    @(posedge clk_sys);
    sleep_active <= 1'h0;
    ccp_unlock <= 1'h0;
    wr(I_SRC, 8'h00);
    rdc("no unlock", I_SRC, 8'h80);
    ccp_unlock <= 1'h1;
    $display("clock out test done");
    wr(I_UCT, 8'h02);
    repeat (100) @(posedge clk_sys);
    chk("ulp forced", ulp_osc_run, 1'h1);
    rd(I_STA, v);
    chk("ulp unreq", v[5], 1'h0);
    periph_req_ulp <= 1'h1;
    rd(I_STA, v);
    chk("ulp gate wait", v[5], 1'h0);
    repeat (150) @(posedge clk_sys);
    rd(I_STA, v);
    chk("ulp req", v[5], 1'h1);
    periph_req_ulp <= 1'h0;
    wr(I_SRC, 8'h81);
    rd(I_STA, v);
    chk("switching", v[0], 1'h1);
    wait_switch(v);
    chk("switch done", v[0], 1'h0);
    chk("ulp main", v[5], 1'h1);
    wr(I_SRC, 8'h80);
    wait_switch(v);
    chk("back fast", v[4:0], 5'h10);
    wr(I_SRC, 8'h83);
    wait_switch(v);
    chk("ext main", {v[7], v[0]}, 2'h2);
    rdc("ext sel", I_SRC, 8'h83);
    wr(I_SRC, 8'h80);
    wait_switch(v);
    chk("fast again", v[4:0], 5'h10);
    periph_req_ext <= 1'h1;
    repeat (60) @(posedge clk_sys);
    rd(I_STA, v);
    chk("ext started", v[7], 1'h1);
    periph_req_ext <= 1'h0;
    $display("source test done");
    wr(I_LCK, 8'h01);
    rdc("lock set", I_LCK, 8'h01);
    wr(I_SRC, 8'h01);
    rdc("src frozen", I_SRC, 8'h80);
    wr(I_PRE, 8'h19);
    rdc("pre frozen", I_PRE, 8'h01);
    wr(I_TRM, 8'h00);
    rdc("trim frozen", I_TRM, 8'h15);
    wr(I_LCK, 8'h00);
    rdc("lock held", I_LCK, 8'h01);
    @(posedge clk_sys);
    fuse_calib_freeze <= 1'h1;
    fuse_freq_select <= 1'h1;
    do_reset();
    rdc("lock fuse", I_LCK, 8'h01);
    rdc("tempco fuse", I_TCO, {4'h8, fuse_tempco_20});
    rdc("trim fuse", I_TRM, {2'h0, fuse_trim_20});
    wr(I_TRM, 8'h00);
    rdc("trim locked", I_TRM, {2'h0, fuse_trim_20});
    @(posedge clk_sys);
    fuse_calib_freeze <= 1'h0;
    fuse_freq_select <= 1'h0;
    do_reset();
    rdc("lock cleared", I_LCK, 8'h00);
    $display("freeze test done");
    end_of_test();
  end
endmodule
`default_nettype wire

// *** src/mcsp_clkctrl.sv ***
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mcsp_clkctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ccp_unlock,
  input  wire logic        fuse_calib_freeze,
  input  wire logic        fuse_freq_select,
  input  wire logic [5:0]  fuse_trim_16,
  input  wire logic [5:0]  fuse_trim_20,
  input  wire logic [3:0]  fuse_tempco_16,
  input  wire logic [3:0]  fuse_tempco_20,
  input  wire logic        fast_osc_tick,
  input  wire logic        ulp_osc_tick,
  input  wire logic        ext_clk_tick,
  input  wire logic        fast_osc_analog_ok,
  input  wire logic        ulp_osc_analog_ok,
  input  wire logic        periph_req_fast,
  input  wire logic        periph_req_ulp,
  input  wire logic        periph_req_ext,
  input  wire logic        sleep_active,
  input  wire logic        periph_uses_sysclk,
  output logic             main_clk_en,
  output logic             per_clk_en,
  output logic             clk_out_pin,
  output logic             fast_osc_run,
  output logic             ulp_osc_run,
  output logic [5:0]       fast_osc_trim,
  output logic [3:0]       fast_osc_tempco_trim
);

  // Register state
  logic                sys_clock_out_enable_r;
  mcsp_pkg::mcsp_src_t tgt_r;
  mcsp_pkg::mcsp_src_t sel_r;
  logic                pen_r;
  logic [3:0]          prescaler_division_r;
  logic                freeze_r;
  logic                fast_force_r;
  logic                ulp_force_r;
  logic [5:0]          trim_r;
  logic [3:0]          tco_r;
  logic                calfrz_r;
  logic [31:0]         prdata_r;

  // Clock path state
  logic [6:0]          pre_cnt_r;
  logic [6:0]          pre_cnt_nxt;
  logic                main_en_r;
  logic                per_en_r;
  logic                clk_out_r;

  // Bus decode
  logic [4:0]          idx;
  logic                aligned;
  logic                sel_src;
  logic                sel_pre;
  logic                sel_lock;
  logic                sel_stat;
  logic                sel_fctl;
  logic                sel_ftrim;
  logic                sel_ftco;
  logic                sel_uctl;
  logic                addr_hit;
  logic                setup_ph;
  logic                wr_en;
  logic                wr_ok;
  logic                trim_block;
  logic                we_src;
  logic                we_pre;
  logic                we_lock;
  logic                we_fctl;
  logic                we_ftrim;
  logic                we_ftco;
  logic                we_uctl;
  logic [1:0]          new_src;
  logic                new_src_ok;
  logic [7:0]          rd_byte;

  // Oscillator side
  logic [2:0]          osc_tick;
  logic [2:0]          osc_ok;
  logic [2:0]          osc_keep;
  logic [2:0]          periph_req;
  logic [2:0]          sel_oh;
  logic [2:0]          tgt_oh;
  logic [2:0]          req;
  logic [2:0]          gate_stable;
  logic [2:0]          gate_en;
  logic                switching;
  logic                tgt_ready;
  logic                main_tick;
  logic [6:0]          div_eff;
  logic                pre_wrap;
  logic                out_allow;
  mcsp_pkg::mcsp_status_t status;

  assign idx       = paddr[6:2];
  assign aligned   = (paddr[1:0] == 2'h0) & ~paddr[7];
  assign sel_src   = aligned & (idx == mcsp_pkg::IDX_SRC);
  assign sel_pre   = aligned & (idx == mcsp_pkg::IDX_PRE);
  assign sel_lock  = aligned & (idx == mcsp_pkg::IDX_LOCK);
  assign sel_stat  = aligned & (idx == mcsp_pkg::IDX_STAT);
  assign sel_fctl  = aligned & (idx == mcsp_pkg::IDX_FCTL);
  assign sel_ftrim = aligned & (idx == mcsp_pkg::IDX_FTRIM);
  assign sel_ftco  = aligned & (idx == mcsp_pkg::IDX_FTCO);
  assign sel_uctl  = aligned & (idx == mcsp_pkg::IDX_UCTL);
  assign addr_hit  = sel_src | sel_pre | sel_lock | sel_stat
                   | sel_fctl | sel_ftrim | sel_ftco | sel_uctl;

  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_hit;

  // Unlock window comes from the change protection logic
  assign wr_ok = wr_en & ccp_unlock; // R19 R20 R21

  // Frozen main clock also freezes the active fast oscillator trims
  assign trim_block = calfrz_r // R18
                    | (freeze_r & (sel_r == mcsp_pkg::SRC_FAST)); // R08
  assign we_src   = wr_ok & sel_src & ~freeze_r; // R08
  assign we_pre   = wr_ok & sel_pre & ~freeze_r; // R08
  assign we_lock  = wr_ok & sel_lock & ~freeze_r; // R09
  assign we_fctl  = wr_ok & sel_fctl;
  assign we_ftrim = wr_ok & sel_ftrim & ~trim_block;
  assign we_ftco  = wr_ok & sel_ftco & ~trim_block;
  assign we_uctl  = wr_ok & sel_uctl;

  assign new_src    = pwdata[1:0];
  assign new_src_ok = (new_src != mcsp_pkg::SRC_RSVD); // R03

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_clock_out_enable_r <= mcsp_pkg::RST_SRC[mcsp_pkg::SYS_CLOCK_OUT_ENABLE_BIT];
      tgt_r    <= mcsp_pkg::mcsp_src_t'(mcsp_pkg::RST_SRC[1:0]); // R07
      pen_r    <= mcsp_pkg::RST_PRE[mcsp_pkg::PEN_BIT]; // R07
      prescaler_division_r   <= mcsp_pkg::RST_PRE[4:1]; // R07
    end else begin
      if (we_src) begin
        sys_clock_out_enable_r <= pwdata[mcsp_pkg::SYS_CLOCK_OUT_ENABLE_BIT]; // R01
      end
      if (we_src && new_src_ok) begin
        tgt_r <= mcsp_pkg::mcsp_src_t'(new_src); // R03
      end
      if (we_pre) begin
        pen_r  <= pwdata[mcsp_pkg::PEN_BIT]; // R06
        prescaler_division_r <= pwdata[mcsp_pkg::PRESCALER_DIVISION_LSB +: 4]; // R04
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      freeze_r <= fuse_calib_freeze; // R10
      calfrz_r <= fuse_calib_freeze; // R18
    end else if (we_lock && pwdata[0]) begin
      freeze_r <= 1'b1; // R08
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fast_force_r <= mcsp_pkg::RST_OSC[mcsp_pkg::FORCE_BIT];
      ulp_force_r  <= mcsp_pkg::RST_OSC[mcsp_pkg::FORCE_BIT];
      trim_r <= fuse_freq_select ? fuse_trim_20 : fuse_trim_16; // R17
      tco_r  <= fuse_freq_select ? fuse_tempco_20 : fuse_tempco_16;
    end else begin
      if (we_fctl) begin
        fast_force_r <= pwdata[mcsp_pkg::FORCE_BIT]; // R14
      end
      if (we_uctl) begin
        ulp_force_r <= pwdata[mcsp_pkg::FORCE_BIT]; // R14
      end
      if (we_ftrim) begin
        trim_r <= pwdata[5:0]; // R17
      end
      if (we_ftco) begin
        tco_r <= pwdata[3:0];
      end
    end
  end

  // Oscillator requests; index 0 fast, 1 ULP, 2 external
  assign osc_tick   = {ext_clk_tick, ulp_osc_tick, fast_osc_tick};
  assign osc_ok     = {1'b1, ulp_osc_analog_ok, fast_osc_analog_ok};
  assign osc_keep   = {1'b0, ulp_force_r, fast_force_r};
  assign periph_req = {periph_req_ext, periph_req_ulp, periph_req_fast};
  assign sel_oh     = {sel_r == mcsp_pkg::SRC_EXT,
                       sel_r == mcsp_pkg::SRC_ULP,
                       sel_r == mcsp_pkg::SRC_FAST}; // R03
  assign tgt_oh     = {tgt_r == mcsp_pkg::SRC_EXT,
                       tgt_r == mcsp_pkg::SRC_ULP,
                       tgt_r == mcsp_pkg::SRC_FAST};

  for (genvar i = 0; i < 3; i++) begin : g_osc
    assign req[i] = sel_oh[i] | tgt_oh[i] | periph_req[i]; // R15
    mcsp_osc_gate #(
      .GATE_CYC (i == 2 ? mcsp_pkg::GATE_EXT_CYC : mcsp_pkg::GATE_OSC_CYC)
    ) u_gate (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .req       (req[i]),
      .keep_on   (osc_keep[i]),
      .analog_ok (osc_ok[i]),
      .osc_tick  (osc_tick[i]),
      .stable    (gate_stable[i]),
      .clk_en    (gate_en[i])
    );
  end

  assign fast_osc_run = req[0] | fast_force_r; // R14
  assign ulp_osc_run  = req[1] | ulp_force_r; // R14

  // Source switch completes only once the new source is stable
  assign switching = (tgt_r != sel_r); // R13
  assign tgt_ready = |(tgt_oh & gate_stable); // R13

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_r <= mcsp_pkg::mcsp_src_t'(mcsp_pkg::RST_SRC[1:0]); // R07
    end else if (switching && tgt_ready) begin
      sel_r <= tgt_r; // R13
    end
  end

  // Prescaler counts main clock ticks
  assign main_tick   = |(sel_oh & gate_en);
  assign div_eff     = pen_r ? mcsp_pkg::mcsp_div(prescaler_division_r) : 7'h01; // R04 R06
  assign pre_wrap    = (pre_cnt_r >= div_eff - 7'h01); // R05
  assign pre_cnt_nxt = !main_tick ? pre_cnt_r
                     : (pre_wrap ? 7'h00 : pre_cnt_r + 7'h01);
  assign out_allow   = ~sleep_active | periph_uses_sysclk; // R02

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_cnt_r <= 7'h00;
      main_en_r <= 1'b0;
      per_en_r  <= 1'b0;
      clk_out_r <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      main_en_r <= main_tick;
      per_en_r  <= main_tick & pre_wrap; // R06
      clk_out_r <= main_tick & sys_clock_out_enable_r & out_allow; // R01 R02
    end
  end

  assign main_clk_en          = main_en_r;
  assign per_clk_en           = per_en_r;
  assign clk_out_pin          = clk_out_r;
  assign fast_osc_trim        = trim_r;
  assign fast_osc_tempco_trim = tco_r;

  // Status; gate stable already drops without a request
  assign status.ext_clock_started = gate_stable[2]; // R11
  assign status.rsvd6             = 1'b0;
  assign status.ulp_osc_stable    = gate_stable[1]; // R12
  assign status.fast_osc_stable   = gate_stable[0]; // R12
  assign status.rsvd3             = 3'h0;
  assign status.source_switching  = switching; // R13

  // Read mux; reserved bits come back as zero
  assign rd_byte =
      sel_src   ? {sys_clock_out_enable_r, 5'h00, tgt_r} // R23
    : sel_pre   ? {3'h0, prescaler_division_r, pen_r}
    : sel_lock  ? {7'h00, freeze_r}
    : sel_stat  ? status
    : sel_fctl  ? {6'h00, fast_force_r, 1'b0}
    : sel_ftrim ? {2'h0, trim_r}
    : sel_ftco  ? {calfrz_r, 3'h0, tco_r}
    : sel_uctl  ? {6'h00, ulp_force_r, 1'b0}
    : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_r <= {24'h000000, rd_byte};
    end
  end

  assign prdata = prdata_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  src_write_a : assert property ( // R03
    we_src && new_src == 2'h3 |=> tgt_r == mcsp_pkg::SRC_EXT)
    else $error("external source code not taken");
  pen_off_a : assert property ( // R06
    !pen_r && main_tick |=> per_clk_en && main_clk_en)
    else $error("undivided clock lost a pulse");
  div_six_a : assert property ( // R04
    pen_r && prescaler_division_r == 4'h8 && main_tick && pre_wrap
    |-> pre_cnt_r == 7'h05)
    else $error("divide by six wraps at wrong count");
  freeze_ctrl_a : assert property ( // R08
    freeze_r && wr_en |=> $stable({pen_r, prescaler_division_r, sys_clock_out_enable_r, tgt_r}))
    else $error("frozen control changed");
  lock_stuck_a : assert property (freeze_r |=> freeze_r) // R09
    else $error("freeze released without reset");
  unlock_need_a : assert property ( // R21
    wr_en && !ccp_unlock
    |=> $stable({sys_clock_out_enable_r, pen_r, prescaler_division_r, trim_r, tco_r, freeze_r}))
    else $error("protected write took effect without unlock");
  switch_done_a : assert property ( // R13
    switching && tgt_ready && !we_src
    |=> sel_r == $past(tgt_r) && !status.source_switching)
    else $error("source switch did not finish");
  switch_hold_a : assert property ( // R13
    switching && !tgt_ready |=> sel_r == $past(sel_r))
    else $error("switched before new source stable");
  sys_clock_out_enable_sleep_a : assert property ( // R02
    clk_out_pin |-> $past(out_allow) && $past(sys_clock_out_enable_r))
    else $error("clock out while not allowed");
  calib_lock_a : assert property ( // R18
    calfrz_r && wr_en |=> $stable(trim_r) && $stable(tco_r))
    else $error("fuse locked trim changed");

  switch_cov : cover property (switching ##[1:40] !switching);
  div_cov : cover property (pen_r && per_clk_en ##[2:80] per_clk_en);
  freeze_cov : cover property (!freeze_r ##1 freeze_r);
  sys_clock_out_enable_cov : cover property (clk_out_pin);
endmodule
`default_nettype wire

// *** src/mcsp_osc_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcsp_osc_gate #(
  parameter int unsigned GATE_CYC = mcsp_pkg::GATE_OSC_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic req,
  input  wire logic keep_on,
  input  wire logic analog_ok,
  input  wire logic osc_tick,
  output logic      stable,
  output logic      clk_en
);
  localparam int unsigned CW = $clog2(GATE_CYC + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          stable_r;
  logic          stable_nxt;
  logic          counting;

  // Kept-on oscillator needs no analog start-up wait
  assign counting   = req & (analog_ok | keep_on) & osc_tick & ~stable_r; // R16
  assign cnt_nxt    = !req ? '0 : (counting ? cnt_r + 1'b1 : cnt_r);
  assign stable_nxt = req & (stable_r | (cnt_nxt == CW'(GATE_CYC))); // R16

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r    <= '0;
      stable_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign stable = stable_r;
  assign clk_en = stable_r & osc_tick; // R15

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  no_req_quiet_a : assert property (!req |=> !stable && !clk_en) // R15
    else $error("oscillator output without request");
  open_late_a : assert property ($rose(stable) |-> $past(req)) // R16
    else $error("gate opened without request");
endmodule
`default_nettype wire

// *** src/mcsp_pkg.sv ***
// How it works
// R01 - Clock out bit drives system clock pin
// R02 - Pin quiet in sleep unless clock used
// R03 - Source select codes: fast, ULP, external
// R04 - Prescaler codes map to fixed divisors
// R05 - Divisor changes apply on the fly
// R06 - Prescaler off passes main clock undivided
// R07 - Reset: fast oscillator, divide by six
// R08 - Freeze blocks control and active calibration writes
// R09 - Freeze register locked until hardware reset
// R10 - Freeze bit loaded from fuse at reset
// R11 - External clock started flag reads one
// R12 - Stable flags only while oscillator requested
// R13 - Switching flag until new source stable
// R14 - Force bit keeps oscillator running always
// R15 - No oscillator output without a request
// R16 - Gate opens four cycles, force skips analog; the external clock gate opens after two
// R17 - Fast trim loaded from fuse select
// R18 - Fuse calibration lock blocks trim writes
// R19 - All but status need change unlock
// R20 - Software unlocks then writes within four
// R21 - Write without unlock leaves register unchanged
// R22 - Software keeps peripheral clock within limits
// R23 - Reserved bits read zero, ignore writes
`default_nettype none
package mcsp_pkg;

  localparam logic [4:0] IDX_SRC   = 5'h00;
  localparam logic [4:0] IDX_PRE   = 5'h01;
  localparam logic [4:0] IDX_LOCK  = 5'h02;
  localparam logic [4:0] IDX_STAT  = 5'h03;
  localparam logic [4:0] IDX_FCTL  = 5'h10;
  localparam logic [4:0] IDX_FTRIM = 5'h11;
  localparam logic [4:0] IDX_FTCO  = 5'h12;
  localparam logic [4:0] IDX_UCTL  = 5'h18;

  localparam int unsigned SYS_CLOCK_OUT_ENABLE_BIT = 7;
  localparam int unsigned PEN_BIT    = 0;
  localparam int unsigned PRESCALER_DIVISION_LSB   = 1;
  localparam int unsigned FORCE_BIT  = 1;

  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_PRE = 8'h11;
  localparam logic [7:0] RST_OSC = 8'h00;

  localparam int unsigned GATE_OSC_CYC = 4;
  localparam int unsigned GATE_EXT_CYC = 2;

  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_ULP  = 2'h1,
    SRC_RSVD = 2'h2,
    SRC_EXT  = 2'h3
  } mcsp_src_t;

  typedef struct packed {
    logic       ext_clock_started;
    logic       rsvd6;
    logic       ulp_osc_stable;
    logic       fast_osc_stable;
    logic [2:0] rsvd3;
    logic       source_switching;
  } mcsp_status_t;

  function automatic logic [6:0] mcsp_div(input logic [3:0] code);
    case (code)
      4'h0:    mcsp_div = 7'h02;
      4'h1:    mcsp_div = 7'h04;
      4'h2:    mcsp_div = 7'h08;
      4'h3:    mcsp_div = 7'h10;
      4'h4:    mcsp_div = 7'h20;
      4'h5:    mcsp_div = 7'h40;
      4'h8:    mcsp_div = 7'h06;
      4'h9:    mcsp_div = 7'h0A;
      4'hA:    mcsp_div = 7'h0C;
      4'hB:    mcsp_div = 7'h18;
      4'hC:    mcsp_div = 7'h30;
      default: mcsp_div = 7'h02;
    endcase
  endfunction

endpackage
`default_nettype wire
